// ==== hw/mcec_checker.sv ====
// Motion command error checker: command checks, stop request, host words
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Circular move with supplemental feed above max feed gives 002C.
// - Traverse winding feed above max feed also gives 002C.
// - Two-speed command with second speed not below first gives 002D.
// - Interrupt feed ending without interrupt input gives 002E.
// - Interrupt feed with reversed direction on interrupt gives 002F.
// - Circular command with negative rotation count gives 0030.
// - Traverse with feed <= 0, end windings < 0 or total < 1 gives 0030.
// - Traverse whose rotating axis is not unlimited-feed gives 0031.
// - Indirect aux output code outside 0 to 255 gives 0032.
// - Continuing a disturbed traverse is refused with 0033.
// - Traverse continues only if no axis error and no move during a deceleration stop was seen.
// - Missing host answer to an aux code notice gives 0034.
// - An error found while none is held sets status bit 14 and puts the code in the next word.
module mcec_checker
  import mcec_pkg::*;
#(
  parameter int AUX_TIMEOUT = AUX_TIMEOUT_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Command to check
  input wire logic cmd_valid,
  input wire mcec_cmd_t cmd,
  input wire logic signed [DATA_W-1:0] max_interp_feed,
  // Motion feedback
  input wire logic intr_input,
  input wire logic intr_feed_done,
  input wire logic axis_error,
  input wire logic axis_moved_other,
  input wire logic decel_stopped,
  // Host handshake
  input wire logic aux_host_ack,
  input wire logic host_err_reset,
  // Results
  output logic decel_stop_req,
  output logic restart_from_first,
  output logic aux_notify,
  output logic [DATA_W-1:0] aux_code,
  output mcec_host_if_t host_words
);

  logic ctrl_tick;
  logic intr_s1_ff, intr_s2_ff, intr_s3_ff, intr_ff;
  logic err_ff;
  logic [CODE_W-1:0] code_ff;
  logic intr_wait_ff, intr_seen_ff;
  logic traverse_active_ff, traverse_dirty_ff;
  logic aux_wait_ff;
  logic [31:0] aux_cnt_ff;
  logic aux_notify_ff;
  logic [DATA_W-1:0] aux_code_ff;
  logic [CODE_W-1:0] nxt_code;
  logic nxt_err;
  logic [CODE_W-1:0] cmd_code;
  logic aux_timeout;
  logic intr_fail;

  mcec_ctrl_tick u_tick (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(ctrl_tick)
  );

  // Interrupt pin is asynchronous: accept a change when stages 2 and 3 agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      intr_s1_ff <= 1'b0;
      intr_s2_ff <= 1'b0;
      intr_s3_ff <= 1'b0;
      intr_ff <= 1'b0;
    end else begin
      intr_s1_ff <= intr_input;
      intr_s2_ff <= intr_s1_ff;
      intr_s3_ff <= intr_s2_ff;
      if (intr_s2_ff == intr_s3_ff) begin
        intr_ff <= intr_s3_ff;
      end
    end
  end

  // Per-command checks; first failing check wins
  always_comb begin
    cmd_code = CODE_NONE;
    case (cmd.op)
      MCEC_OP_CIRC_CW, MCEC_OP_CIRC_CCW: begin
        if (cmd.rotations < 0) begin
          cmd_code = CODE_NEG_ROTATION;
        end else if (cmd.feed_rate > max_interp_feed) begin
          cmd_code = CODE_SUP_SPEED;
        end
      end
      MCEC_OP_TWO_SPEED: begin
        if (cmd.speed_ref2 >= cmd.speed_ref1) begin
          cmd_code = CODE_SECOND_SPEED;
        end
      end
      MCEC_OP_INTR_FEED: begin
        if (cmd.dir_no_intr != cmd.dir_with_intr) begin
          cmd_code = CODE_POS_REVERSE;
        end
      end
      MCEC_OP_TRAVERSE: begin
        if (!cmd.rot_axis_unlimited) begin
          cmd_code = CODE_AXIS_SETTING;
        end else if (cmd.feed_rate <= 0 || cmd.end_windings < 0 ||
                     cmd.total_windings < 1) begin
          cmd_code = CODE_NEG_ROTATION;
        end else if (cmd.feed_rate > max_interp_feed) begin
          cmd_code = CODE_SUP_SPEED;
        end
      end
      MCEC_OP_TRAVERSE_CONT: begin
        if (!traverse_active_ff || traverse_dirty_ff) begin
          cmd_code = CODE_CONTINUATION;
        end
      end
      MCEC_OP_AUX_OUT: begin
        if (cmd.aux_indirect &&
            (cmd.aux_value < 0 || cmd.aux_value > AUX_CODE_MAX)) begin
          cmd_code = CODE_AUX_RANGE;
        end
      end
      default: begin
        cmd_code = CODE_NONE;
      end
    endcase
  end

  assign intr_fail = intr_wait_ff && intr_feed_done && !intr_seen_ff &&
                     !intr_ff;
  assign aux_timeout = aux_wait_ff && !aux_host_ack && ctrl_tick &&
                       (aux_cnt_ff >= 32'(AUX_TIMEOUT - 1));

  // Error latch: the first error is held until the host resets it
  always_comb begin
    nxt_err = err_ff;
    nxt_code = code_ff;
    if (!err_ff) begin
      if (cmd_valid && cmd_code != CODE_NONE) begin
        nxt_err = 1'b1;
        nxt_code = cmd_code;
      end else if (intr_fail) begin
        nxt_err = 1'b1;
        nxt_code = CODE_NO_INTERRUPT;
      end else if (aux_timeout) begin
        nxt_err = 1'b1;
        nxt_code = CODE_AUX_TIMEOUT;
      end
    end else if (host_err_reset) begin
      nxt_err = 1'b0;
      nxt_code = CODE_NONE;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      err_ff <= 1'b0;
      code_ff <= CODE_NONE;
    end else begin
      err_ff <= nxt_err;
      code_ff <= nxt_code;
    end
  end

  // Interrupt feed tracking
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      intr_wait_ff <= 1'b0;
      intr_seen_ff <= 1'b0;
    end else if (cmd_valid && cmd.op == MCEC_OP_INTR_FEED &&
                 cmd_code == CODE_NONE && !err_ff) begin
      intr_wait_ff <= 1'b1;
      intr_seen_ff <= 1'b0;
    end else if (intr_wait_ff && intr_feed_done) begin
      intr_wait_ff <= 1'b0;
    end else if (intr_wait_ff && intr_ff) begin
      intr_seen_ff <= 1'b1;
    end
  end

  // Traverse state: any disturbance marks it unfit to continue
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      traverse_active_ff <= 1'b0;
      traverse_dirty_ff <= 1'b0;
    end else if (cmd_valid && cmd.op == MCEC_OP_TRAVERSE &&
                 cmd_code == CODE_NONE && !err_ff) begin
      traverse_active_ff <= 1'b1;
      traverse_dirty_ff <= 1'b0;
    end else if (cmd_valid && cmd.op == MCEC_OP_TRAVERSE_CONT) begin
      // A refused continuation forces a restart, so drop the traverse
      traverse_active_ff <= traverse_active_ff && !traverse_dirty_ff;
      traverse_dirty_ff <= 1'b0;
    end else if (traverse_active_ff &&
                 (axis_error || (decel_stopped && axis_moved_other))) begin
      traverse_dirty_ff <= 1'b1;
    end
  end

  // Aux code notice and response wait, counted in control cycles
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aux_wait_ff <= 1'b0;
      aux_cnt_ff <= 32'h0;
      aux_notify_ff <= 1'b0;
      aux_code_ff <= '0;
    end else if (cmd_valid && cmd.op == MCEC_OP_AUX_OUT &&
                 cmd_code == CODE_NONE && !err_ff) begin
      aux_wait_ff <= 1'b1;
      aux_cnt_ff <= 32'h0;
      aux_notify_ff <= 1'b1;
      aux_code_ff <= cmd.aux_value;
    end else if (aux_wait_ff && (aux_host_ack || aux_timeout)) begin
      aux_wait_ff <= 1'b0;
      aux_notify_ff <= 1'b0;
    end else if (aux_wait_ff && ctrl_tick) begin
      aux_cnt_ff <= aux_cnt_ff + 32'h1;
    end
  end

  assign aux_notify = aux_notify_ff;
  assign aux_code = aux_code_ff;
  assign decel_stop_req = err_ff;
  assign restart_from_first = err_ff && code_ff == CODE_CONTINUATION;

  always_comb begin
    host_words.status = STATUS_RESET;
    host_words.status[ERR_FLAG_BIT] = err_ff;
    host_words.code = code_ff;
  end

endmodule // mcec_checker
`default_nettype wire

// ==== hw/mcec_pkg.sv ====
// Package for the motion command error checker: codes, types, constants
package mcec_pkg;

  localparam int DATA_W = 32;
  localparam int CODE_W = 16;
  localparam int ERR_FLAG_BIT = 14;
  localparam int REF_CLK_HZ = 50_000_000;

  // Error codes reported to the host
  localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_SUP_SPEED = 16'h002C;
  localparam logic [CODE_W-1:0] CODE_SECOND_SPEED = 16'h002D;
  localparam logic [CODE_W-1:0] CODE_NO_INTERRUPT = 16'h002E;
  localparam logic [CODE_W-1:0] CODE_POS_REVERSE = 16'h002F;
  localparam logic [CODE_W-1:0] CODE_NEG_ROTATION = 16'h0030;
  localparam logic [CODE_W-1:0] CODE_AXIS_SETTING = 16'h0031;
  localparam logic [CODE_W-1:0] CODE_AUX_RANGE = 16'h0032;
  localparam logic [CODE_W-1:0] CODE_CONTINUATION = 16'h0033;
  localparam logic [CODE_W-1:0] CODE_AUX_TIMEOUT = 16'h0034;

  localparam logic signed [DATA_W-1:0] AUX_CODE_MAX = 32'sh000000FF;

  // Aux response timeout, in control cycles, and control cycle length
  localparam int AUX_TIMEOUT_CYCLES = 100;
  localparam int CTRL_CYCLE_US = 1000;
  localparam int CTRL_CYCLE_CLKS = CTRL_CYCLE_US * (REF_CLK_HZ / 1_000_000);
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  typedef enum logic [3:0] {
    MCEC_OP_NONE,
    MCEC_OP_CIRC_CW,
    MCEC_OP_CIRC_CCW,
    MCEC_OP_TWO_SPEED,
    MCEC_OP_INTR_FEED,
    MCEC_OP_TRAVERSE,
    MCEC_OP_TRAVERSE_CONT,
    MCEC_OP_AUX_OUT
  } mcec_op_t;

  // One decoded program command presented for checking
  typedef struct packed {
    mcec_op_t op;
    logic signed [DATA_W-1:0] feed_rate;
    logic signed [DATA_W-1:0] speed_ref1;
    logic signed [DATA_W-1:0] speed_ref2;
    logic signed [DATA_W-1:0] rotations;
    logic signed [DATA_W-1:0] end_windings;
    logic signed [DATA_W-1:0] total_windings;
    logic signed [DATA_W-1:0] aux_value;
    logic aux_indirect;
    logic rot_axis_unlimited;
    logic dir_no_intr;
    logic dir_with_intr;
  } mcec_cmd_t;

  // Status word and error code word seen by the host
  typedef struct packed {
    logic [15:0] status;
    logic [CODE_W-1:0] code;
  } mcec_host_if_t;

endpackage : mcec_pkg

// ==== hw/mcec_ctrl_tick.sv ====
// Control cycle tick generator for the error checker
`timescale 1ns/1ps
`default_nettype none
module mcec_ctrl_tick
  import mcec_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Tick
  output logic tick
);

  logic [31:0] cnt_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 32'h0;
    end else if (cnt_ff == 32'(CTRL_CYCLE_CLKS - 1)) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  assign tick = (cnt_ff == 32'(CTRL_CYCLE_CLKS - 1));

endmodule // mcec_ctrl_tick
`default_nettype wire

// ==== verification/mcec_sva_checker.sv ====
// Port assertions for the motion command error checker
`timescale 1ns/1ps
`default_nettype none
module mcec_sva
  import mcec_pkg::*;
#(parameter int AUX_TIMEOUT = 2)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Command and motion feedback
  input wire logic cmd_valid,
  input wire mcec_cmd_t cmd,
  input wire logic signed [DATA_W-1:0] max_interp_feed,
  input wire logic intr_input,
  input wire logic intr_feed_done,
  input wire logic axis_error,
  input wire logic axis_moved_other,
  input wire logic decel_stopped,
  // Host side
  input wire logic aux_host_ack,
  input wire logic host_err_reset,
  input wire logic decel_stop_req,
  input wire logic restart_from_first,
  input wire logic aux_notify,
  input wire logic [DATA_W-1:0] aux_code,
  input wire mcec_host_if_t host_words
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Commands meeting a host reset are left out to keep the checks simple
  wire logic go = cmd_valid && !decel_stop_req && !host_err_reset;
  wire logic circ = cmd.op inside {MCEC_OP_CIRC_CW, MCEC_OP_CIRC_CCW};
  wire logic [CODE_W-1:0] cd = host_words.code;
  wire logic flg = host_words.status[ERR_FLAG_BIT];
  sup_speed_a:
  assert property (go && circ && cmd.rotations >= 0 && cmd.feed_rate >
    max_interp_feed |=> cd == CODE_SUP_SPEED) else $error("sup speed");
  neg_rot_a:
  assert property (go && circ && cmd.rotations < 0
    |=> cd == CODE_NEG_ROTATION) else $error("neg rotation");
  two_speed_a:
  assert property (go && cmd.op == MCEC_OP_TWO_SPEED && cmd.speed_ref2 >=
    cmd.speed_ref1 |=> flg && cd == CODE_SECOND_SPEED) else $error("2nd");
  axis_set_a:
  assert property (go && cmd.op == MCEC_OP_TRAVERSE && !cmd.rot_axis_unlimited
    |=> cd == CODE_AXIS_SETTING) else $error("axis setting");
  aux_range_a:
  assert property (go && cmd.op == MCEC_OP_AUX_OUT && cmd.aux_indirect &&
    (cmd.aux_value < 0 || cmd.aux_value > AUX_CODE_MAX)
    |=> cd == CODE_AUX_RANGE && !aux_notify) else $error("aux range");
  flag_code_a:
  assert property (flg |-> cd != CODE_NONE && decel_stop_req)
    else $error("flag without code");
  err_hold_a:
  assert property (decel_stop_req && !host_err_reset
    |=> decel_stop_req && $stable(cd)) else $error("error not held");
  err_clear_a:
  assert property (host_err_reset && decel_stop_req |=> !decel_stop_req && !flg)
    else $error("error not cleared");
  restart_a:
  assert property (restart_from_first |-> flg && cd == CODE_CONTINUATION)
    else $error("restart without 0033");
  aux_ack_a:
  assert property (aux_notify && aux_host_ack && !cmd_valid |=> !aux_notify)
    else $error("notice not dropped");
  cover property (go && cmd.op == MCEC_OP_TWO_SPEED);
  cover property (aux_notify && aux_host_ack);
  cover property (restart_from_first);
endmodule // mcec_sva
bind mcec_checker mcec_sva #(.AUX_TIMEOUT(AUX_TIMEOUT)) sva_u (.*);
`default_nettype wire

// ==== verification/mcec_host_model.sv ====
// Host controller model that answers aux code notices
`timescale 1ns/1ps
`default_nettype none
module mcec_host_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Handshake; mode 0 prompt, 1 slow, 2 stopped ladder that never answers
  input wire logic aux_notify,
  input wire logic [1:0] mode,
  output logic aux_host_ack
);
  int wt;
  always @(negedge ref_clk or negedge nrst) begin
    if (!nrst || !aux_notify || mode == 2'h2) begin
      wt <= 0;
      aux_host_ack <= 1'b0;
    end else begin
      wt <= wt + 1;
      aux_host_ack <= wt >= (mode == 2'h1 ? 20 : 0);
    end
  end
endmodule // mcec_host_model
`default_nettype wire

// ==== verification/mcec_checker_tb.sv ====
// Self-checking bench for the motion command error checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module mcec_checker_tb;
  import mcec_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, intr_input = 1'b0;
  logic intr_feed_done = 1'b0, axis_error = 1'b0, axis_moved_other = 1'b0;
  logic decel_stopped = 1'b0, host_err_reset = 1'b0, aux_host_ack;
  logic decel_stop_req, restart_from_first, aux_notify;
  logic [1:0] mode = 2'h0;
  logic [DATA_W-1:0] aux_code;
  logic signed [DATA_W-1:0] max_interp_feed = 32'sh00001000;
  mcec_cmd_t cmd = '0;
  mcec_host_if_t host_words;
  wire logic flg = host_words.status[ERR_FLAG_BIT];
  int n_mismatch = 0, n_tests = 0;
  always #10 ref_clk = ~ref_clk;
  // One control cycle of patience keeps the timeout case inside the run limit
  mcec_checker #(.AUX_TIMEOUT(1)) dut_u (.*);
  mcec_host_model host_u (.*);
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(negedge ref_clk);
  endtask
  function automatic mcec_cmd_t mk(mcec_op_t op);
    return '{op, 32'sh64, 32'shC8, 32'sh64, 32'sh1, 32'sh0, 32'sh1,
             32'sh5, 1'b1, 1'b1, 1'b0, 1'b0};
  endfunction
  task automatic issue(mcec_cmd_t c);
    // Let an edge pass so back-to-back commands never glitch valid
    tick();
    cmd = c;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
  endtask
  task automatic clr();
    host_err_reset = 1'b1;
    tick();
    host_err_reset = 1'b0;
    `CHK("clear", 1'b0, flg)
  endtask
  task automatic send(mcec_cmd_t c, logic [CODE_W-1:0] e, bit keep = 1'b0);
    issue(c);
    `CHK("code", e, host_words.code)
    `CHK("stop", e != CODE_NONE, decel_stop_req)
    if (e != CODE_NONE && !keep) clr();
  endtask
  // Bounded wait on the error flag or on the aux notice
  task automatic wait_for(bit on_flg, logic v, int n);
    logic s;
    for (int i = 0; i < n; i++) begin
      s = on_flg ? flg : aux_notify;
      if (s === v) return;
      tick();
    end
    `CHK("wait", v, s)
    give_verdict();
  endtask
  task automatic t_circ();
    mcec_cmd_t c;
    for (int i = 0; i < 2; i++) begin
      c = mk(i ? MCEC_OP_CIRC_CCW : MCEC_OP_CIRC_CW);
      c.feed_rate = max_interp_feed;
      send(c, CODE_NONE);
      c.feed_rate = max_interp_feed + 1;
      send(c, CODE_SUP_SPEED);
      c.rotations = -32'sh1;
      send(c, CODE_NEG_ROTATION);
    end
    $display("circular done");
  endtask
  task automatic t_two();
    mcec_cmd_t c = mk(MCEC_OP_TWO_SPEED);
    send(c, CODE_NONE);
    c.speed_ref2 = c.speed_ref1;
    send(c, CODE_SECOND_SPEED, 1'b1);
    send(mk(MCEC_OP_TRAVERSE_CONT), CODE_SECOND_SPEED);
    $display("two speed done");
  endtask
  task automatic t_trav();
    mcec_cmd_t c = mk(MCEC_OP_TRAVERSE);
    c.feed_rate = max_interp_feed + 1;
    send(c, CODE_SUP_SPEED);
    c.feed_rate = 32'sh0;
    send(c, CODE_NEG_ROTATION);
    c.rot_axis_unlimited = 1'b0;
    send(c, CODE_AXIS_SETTING);
    c = mk(MCEC_OP_TRAVERSE);
    c.end_windings = -32'sh1;
    send(c, CODE_NEG_ROTATION);
    c.end_windings = 32'sh0;
    c.total_windings = 32'sh0;
    send(c, CODE_NEG_ROTATION);
    $display("traverse done");
  endtask
  task automatic t_aux();
    mcec_cmd_t c = mk(MCEC_OP_AUX_OUT);
    c.aux_value = AUX_CODE_MAX;
    send(c, CODE_NONE);
    `CHK("notify", 1'b1, aux_notify)
    tick(3);
    `CHK("aux", 32'h000000FF, aux_code)
    c.aux_value = AUX_CODE_MAX + 1;
    send(c, CODE_AUX_RANGE);
    c.aux_value = -32'sh1;
    send(c, CODE_AUX_RANGE);
    c.aux_indirect = 1'b0;
    mode = 2'h1;
    send(c, CODE_NONE);
    wait_for(1'b0, 1'b0, 40);
    mode = 2'h2;
    send(c, CODE_NONE);
    wait_for(1'b1, 1'b1, 60000);
    `CHK("timeout", CODE_AUX_TIMEOUT, host_words.code)
    clr();
    $display("aux done");
  endtask
  task automatic t_intr();
    mcec_cmd_t c = mk(MCEC_OP_INTR_FEED);
    send(c, CODE_NONE);
    intr_feed_done = 1'b1;
    tick();
    intr_feed_done = 1'b0;
    wait_for(1'b1, 1'b1, 4);
    `CHK("no input", CODE_NO_INTERRUPT, host_words.code)
    clr();
    send(c, CODE_NONE);
    intr_input = 1'b1;
    tick(6);
    intr_feed_done = 1'b1;
    tick();
    intr_feed_done = 1'b0;
    intr_input = 1'b0;
    tick();
    `CHK("seen", CODE_NONE, host_words.code)
    c.dir_with_intr = 1'b1;
    issue(c);
    intr_input = 1'b1;
    wait_for(1'b1, 1'b1, 10);
    `CHK("reverse", CODE_POS_REVERSE, host_words.code)
    intr_input = 1'b0;
    clr();
    $display("interrupt feed done");
  endtask
  task automatic t_cont();
    mcec_cmd_t t = mk(MCEC_OP_TRAVERSE), k = mk(MCEC_OP_TRAVERSE_CONT);
    send(k, CODE_CONTINUATION, 1'b1);
    `CHK("restart", 1'b1, restart_from_first)
    clr();
    send(t, CODE_NONE);
    decel_stopped = 1'b1;
    tick(2);
    send(k, CODE_NONE);
    axis_moved_other = 1'b1;
    tick(2);
    axis_moved_other = 1'b0;
    send(k, CODE_CONTINUATION);
    decel_stopped = 1'b0;
    send(t, CODE_NONE);
    axis_error = 1'b1;
    tick(2);
    axis_error = 1'b0;
    send(k, CODE_CONTINUATION);
    $display("continuation done");
  endtask
  task automatic t_rst();
    mcec_cmd_t c = mk(MCEC_OP_TWO_SPEED);
    c.speed_ref2 = c.speed_ref1;
    send(c, CODE_SECOND_SPEED, 1'b1);
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick();
    `CHK("reset words", 32'h0, host_words)
    `CHK("reset stop", 1'b0, decel_stop_req)
    send(mk(MCEC_OP_TWO_SPEED), CODE_NONE);
    $display("mid reset done");
  endtask
  initial begin
    tick(4);
    nrst = 1'b1;
    tick();
    `CHK("reset", 32'h0, host_words)
    t_circ();
    t_two();
    t_trav();
    t_intr();
    t_cont();
    t_rst();
    t_aux();
    give_verdict();
  end
endmodule // mcec_checker_tb
`default_nettype wire
